// ===== rtl/nvm_ctl.sv
// Overview of operation
// - divider readable always; one write normal, unlimited special, only while latch clear
// - at reset divider 9:8 from shadow high bits 1:0, 7:0 from shadow low
// - zero divider never starts a cycle and blocks writes to latch control
// - config 7:4 from shadow, bit3 one, wait-stop one, lock and dummy zero
// - debug lockout disable bit readable always, writable only in special mode
// - shadow disable clear steers 0FC0-0FC1 accesses to shadow word; special-mode write
// - bulk program or erase reaches shadow word only when shadow is enabled
// - wait-stop one gates module clock during wait; always read/write
// - protect lock freezes protect and bulk bits; single write normal, free special
// - block protect writable only while program enable and lock are zero
// - shadow protect set refuses program or erase of shadow word
// - six block protect bits each guard one address range
// - test bits ignore writes and read zero in normal mode
// - bulk protect resets one, forbids bulk and row erase, guarded writes
// - auto-clear ends program enable at cycle end; else software clears both
// - erase select one uses byte and row bits to choose erase size
// - byte erase touches only the latched byte or aligned word
// - latch control captures array bus; frozen while program enable or divider zero
// - program enable sets only when latch already set
// - program enable freezes control bits, array writes and latches
// - protected target never starts the timed cycle, so no auto clear
`timescale 1ns/1ps
`default_nettype none
`include "nvm_ctl_regs.svh"
module nvm_ctl (
	// clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_reset,
	// chip mode and shadow word
	input  wire logic        i_special_mode_n,
	input  wire logic        i_wait_mode,
	input  wire logic [15:0] i_shadow_word,
	// register port
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic [7:0]  i_reg_wdata,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	output logic      [7:0]  o_reg_rdata,
	// array write bus
	input  wire logic        i_arr_wr,
	input  wire logic [11:0] i_arr_addr,
	input  wire logic [15:0] i_arr_wdata,
	input  wire logic        i_arr_word,
	// array control outputs
	output logic             o_latch_active,
	output logic             o_hv_enable,
	output logic             o_erase,
	output logic [1:0]       o_erase_size,
	output logic [11:0]      o_op_addr,
	output logic [15:0]      o_op_data,
	output logic             o_op_word,
	output logic             o_shadow_select,
	output logic             o_debug_lockout_disable,
	output logic             o_module_clk_en,
	output logic [7:0]       o_tick_count
);
	nvm_ctl_pkg::nvm_state_s r_ff, nxt_r;
	logic special, div_zero, wr, tick, prot_hit, shadow_hit, bulk_req;
	logic [5:0] blk_hit;
	logic [7:0] rd;
	logic [7:0] p;
	assign special  = ~i_special_mode_n;
	assign div_zero = (r_ff.div == 10'h000);
	assign bulk_req = r_ff.prog[`NVM_PRG_ERASE] && !r_ff.prog[`NVM_PRG_BYTE];
	assign tick     = (r_ff.presc == r_ff.div - 10'h001) && !div_zero;
	assign shadow_hit = !r_ff.mcr_hi[2] && (r_ff.lat_addr[11:1] == 11'h7E0);
	// per-block address decode
	assign blk_hit[5] = (r_ff.lat_addr[11:10] == 2'b10);
	assign blk_hit[4] = (r_ff.lat_addr[11:9] == 3'b110);
	assign blk_hit[3] = (r_ff.lat_addr[11:8] == 4'hE);
	assign blk_hit[2] = (r_ff.lat_addr[11:7] == 5'h1E);
	assign blk_hit[1] = (r_ff.lat_addr[11:6] == 6'h3E);
	assign blk_hit[0] = (r_ff.lat_addr[11:6] == 6'h3F);
	always_comb begin
		logic bulk;
		bulk = r_ff.prog[`NVM_PRG_ERASE] && !r_ff.prog[`NVM_PRG_BYTE];
		prot_hit = 1'b0;
		if (!bulk && |(blk_hit & r_ff.prot[5:0]))
			prot_hit = 1'b1;
		if (bulk && |r_ff.prot[5:0])
			prot_hit = 1'b1;
		if (bulk && r_ff.prog[`NVM_PRG_BULK_PROT])
			prot_hit = 1'b1;
		if ((shadow_hit || (bulk && !r_ff.mcr_hi[2])) && r_ff.prot[`NVM_PROT_SHP])
			prot_hit = 1'b1;
		if (!r_ff.lat_valid)
			prot_hit = 1'b1;
	end
	always_comb begin
		nxt_r = r_ff;
		wr    = i_reg_wr;
		p     = r_ff.prog;
		nxt_r.boot = 1'b0;
		if (r_ff.boot) begin
			nxt_r.div    = {i_shadow_word[9:8], i_shadow_word[7:0]};
			nxt_r.mcr_hi = i_shadow_word[15:12];
		end
		// prescaler
		nxt_r.presc = tick ? 10'h000 : r_ff.presc + 10'h001;
		if (div_zero)
			nxt_r.presc = 10'h000;
		// register writes
		if (wr && i_reg_addr == `NVM_OFF_DIV_HI && !p[`NVM_PRG_LAT]
			&& (special || !r_ff.div_wr_done)) begin
			nxt_r.div[9:8]     = i_reg_wdata[1:0];
			nxt_r.div_wr_done  = 1'b1;
		end
		if (wr && i_reg_addr == `NVM_OFF_DIV_LO && !p[`NVM_PRG_LAT]
			&& (special || !r_ff.div_wr_done)) begin
			nxt_r.div[7:0]     = i_reg_wdata;
			nxt_r.div_wr_done  = 1'b1;
		end
		if (wr && i_reg_addr == `NVM_OFF_MCR) begin
			if (special)
				nxt_r.mcr_hi[3:2] = i_reg_wdata[7:6];
			nxt_r.wai = i_reg_wdata[`NVM_MCR_WAI];
			nxt_r.dummy_bit = i_reg_wdata[`NVM_MCR_DUMMY];
			if (special || !r_ff.plck_wr_done) begin
				nxt_r.plck         = i_reg_wdata[`NVM_MCR_PLCK];
				nxt_r.plck_wr_done = 1'b1;
			end
		end
		if (wr && i_reg_addr == `NVM_OFF_PROT && !p[`NVM_PRG_PGM] && !r_ff.plck)
			nxt_r.prot = {1'b0, i_reg_wdata[6:0]};
		if (wr && i_reg_addr == `NVM_OFF_TST && special)
			nxt_r.tst = i_reg_wdata;
		if (wr && i_reg_addr == `NVM_OFF_PROG) begin
			if (!p[`NVM_PRG_PGM]) begin
				if (!r_ff.plck)
					nxt_r.prog[`NVM_PRG_BULK_PROT] = i_reg_wdata[`NVM_PRG_BULK_PROT];
				nxt_r.prog[5:2] = {i_reg_wdata[5:4], i_reg_wdata[3:2]};
				if (!div_zero)
					nxt_r.prog[`NVM_PRG_LAT] = i_reg_wdata[`NVM_PRG_LAT];
				if (p[`NVM_PRG_LAT] && i_reg_wdata[`NVM_PRG_LAT])
					nxt_r.prog[`NVM_PRG_PGM] = i_reg_wdata[`NVM_PRG_PGM];
			end else begin
				nxt_r.prog[`NVM_PRG_PGM] = i_reg_wdata[`NVM_PRG_PGM];
			end
		end
		if (!nxt_r.prog[`NVM_PRG_LAT])
			nxt_r.lat_valid = 1'b0;
		// array latch capture, frozen while program enable
		if (i_arr_wr && p[`NVM_PRG_LAT] && !p[`NVM_PRG_PGM]) begin
			nxt_r.lat_addr  = i_arr_addr;
			nxt_r.lat_data  = i_arr_wdata;
			nxt_r.lat_word  = i_arr_word && !i_arr_addr[0];
			nxt_r.lat_valid = 1'b1;
		end
		// timed cycle
		case (r_ff.state)
			nvm_ctl_pkg::NVM_IDLE: begin
				nxt_r.hv    = 1'b0;
				nxt_r.ticks = 16'h0000;
				if (p[`NVM_PRG_PGM] && !div_zero && !prot_hit) begin
					nxt_r.state = nvm_ctl_pkg::NVM_BUSY;
					nxt_r.hv    = 1'b1;
				end
			end
			nvm_ctl_pkg::NVM_BUSY: begin
				if (tick && r_ff.hv)
					nxt_r.ticks = r_ff.ticks + 16'h0001;
				if (!nxt_r.prog[`NVM_PRG_PGM]) begin
					nxt_r.state = nvm_ctl_pkg::NVM_IDLE;
					nxt_r.hv    = 1'b0;
				end else if (r_ff.hv && r_ff.ticks >= 16'(`NVM_PULSE_TICKS)) begin
					nxt_r.hv    = 1'b0;
					// without auto-clear, park here so the pulse is not restarted
					if (p[`NVM_PRG_AUTO]) begin
						nxt_r.prog[`NVM_PRG_PGM] = 1'b0;
						nxt_r.state              = nvm_ctl_pkg::NVM_IDLE;
					end
				end
			end
			default: nxt_r.state = nvm_ctl_pkg::NVM_IDLE;
		endcase
		// read mux
		case (i_reg_addr)
			`NVM_OFF_DIV_HI: rd = {6'h00, r_ff.div[9:8]};
			`NVM_OFF_DIV_LO: rd = r_ff.div[7:0];
			`NVM_OFF_MCR:    rd = {r_ff.mcr_hi, 1'b1, r_ff.wai, r_ff.plck, r_ff.dummy_bit};
			`NVM_OFF_PROT:   rd = r_ff.prot;
			`NVM_OFF_TST:    rd = special ? r_ff.tst : 8'h00;
			`NVM_OFF_PROG:   rd = r_ff.prog;
			default:         rd = 8'h00;
		endcase
		nxt_r.rdata = i_reg_rd ? rd : 8'h00;
	end
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			r_ff       <= '0;
			r_ff.state <= nvm_ctl_pkg::NVM_IDLE;
			r_ff.wai   <= 1'b1;
			r_ff.prot  <= `NVM_PROT_RESET;
			r_ff.prog  <= `NVM_PROG_RESET;
			r_ff.boot  <= 1'b1;
		end else begin
			r_ff <= nxt_r;
		end
	end
	assign o_reg_rdata             = r_ff.rdata;
	assign o_latch_active          = r_ff.prog[`NVM_PRG_LAT];
	assign o_hv_enable             = r_ff.hv;
	assign o_erase                 = r_ff.prog[`NVM_PRG_ERASE];
	assign o_erase_size            = r_ff.prog[`NVM_PRG_BYTE] ? 2'b10
	                               : {1'b0, r_ff.prog[`NVM_PRG_ROW]};
	assign o_op_addr               = r_ff.lat_addr;
	assign o_op_data               = r_ff.lat_data;
	assign o_op_word               = r_ff.lat_word;
	assign o_shadow_select         = shadow_hit;
	assign o_debug_lockout_disable = r_ff.mcr_hi[3];
	assign o_module_clk_en         = !(r_ff.wai && i_wait_mode);
	assign o_tick_count            = r_ff.ticks[7:0];

	a_pgm_needs_lat: assert property (@(posedge i_mclk) disable iff (i_reset)
		$rose(r_ff.prog[`NVM_PRG_PGM]) |-> $past(r_ff.prog[`NVM_PRG_LAT]))
		else $error("program enable rose without latch");
	a_no_hv_div0: assert property (@(posedge i_mclk) disable iff (i_reset)
		$rose(r_ff.hv) |-> $past(r_ff.div) != 10'h000)
		else $error("cycle started with zero divider");
	a_freeze_ctl: assert property (@(posedge i_mclk) disable iff (i_reset)
		$past(r_ff.prog[`NVM_PRG_PGM]) |-> $stable(r_ff.prog[7:1]))
		else $error("control bits moved while programming");
	a_prot_lock: assert property (@(posedge i_mclk) disable iff (i_reset)
		$past(r_ff.plck) && !$past(r_ff.boot) |-> $stable(r_ff.prot))
		else $error("protect changed while locked");
	a_no_hv_prot: assert property (@(posedge i_mclk) disable iff (i_reset)
		$rose(r_ff.hv) |-> !$past(prot_hit))
		else $error("protected target started");
	a_test_zero: assert property (@(posedge i_mclk) disable iff (i_reset)
		$past(i_reg_rd) && $past(i_reg_addr) == `NVM_OFF_TST && !special
		&& $stable(i_special_mode_n) |-> o_reg_rdata == 8'h00)
		else $error("test bits visible in normal mode");
	a_clk_gate: assert property (@(posedge i_mclk) disable iff (i_reset)
		i_wait_mode && r_ff.wai |-> !o_module_clk_en)
		else $error("module clocked in wait");
	a_div_once: assert property (@(posedge i_mclk) disable iff (i_reset)
		$past(r_ff.div_wr_done) && !$past(special) && !$past(r_ff.boot)
		|-> $stable(r_ff.div))
		else $error("divider rewritten in normal mode");

	// a pending start request and its interlocks
	sequence s_pgm_armed;
		r_ff.prog[`NVM_PRG_PGM] && r_ff.state == nvm_ctl_pkg::NVM_IDLE;
	endsequence
	sequence s_start_ok;
		!div_zero && !prot_hit;
	endsequence

	a_start_cycle: assert property (@(posedge i_mclk) disable iff (i_reset)
		s_pgm_armed ##0 s_start_ok |=> r_ff.hv)
		else $error("armed cycle did not start");

	a_blocked_idle: assert property (@(posedge i_mclk) disable iff (i_reset)
		s_pgm_armed ##0 prot_hit |=> !r_ff.hv)
		else $error("protected cycle started");

	a_hv_needs_pgm: assert property (@(posedge i_mclk) disable iff (i_reset)
		r_ff.hv |-> r_ff.prog[`NVM_PRG_PGM])
		else $error("high voltage without program enable");

	a_hv_ends_pulse: assert property (@(posedge i_mclk) disable iff (i_reset)
		r_ff.hv && r_ff.ticks >= 16'(`NVM_PULSE_TICKS) |=> !r_ff.hv)
		else $error("pulse not ended");

	a_auto_clear: assert property (@(posedge i_mclk) disable iff (i_reset)
		r_ff.hv && r_ff.prog[`NVM_PRG_AUTO] && r_ff.ticks >= 16'(`NVM_PULSE_TICKS)
		|=> !r_ff.prog[`NVM_PRG_PGM])
		else $error("program enable not cleared automatically");

	a_manual_hold: assert property (@(posedge i_mclk) disable iff (i_reset)
		r_ff.hv && !r_ff.prog[`NVM_PRG_AUTO] && r_ff.ticks >= 16'(`NVM_PULSE_TICKS)
		&& !i_reg_wr |=> r_ff.prog[`NVM_PRG_PGM])
		else $error("program enable cleared without auto");

	a_no_restart: assert property (@(posedge i_mclk) disable iff (i_reset)
		r_ff.state == nvm_ctl_pkg::NVM_BUSY && !r_ff.hv |=> !r_ff.hv)
		else $error("finished cycle restarted");

	a_lat_frozen: assert property (@(posedge i_mclk) disable iff (i_reset)
		$past(r_ff.prog[`NVM_PRG_PGM]) |-> $stable(r_ff.lat_addr) && $stable(r_ff.lat_data))
		else $error("latches moved while programming");

	a_lat_needs_latch: assert property (@(posedge i_mclk) disable iff (i_reset)
		$changed(r_ff.lat_addr) |-> $past(r_ff.prog[`NVM_PRG_LAT]))
		else $error("address latched with latch control clear");

	a_div_zero_lat: assert property (@(posedge i_mclk) disable iff (i_reset)
		div_zero && !r_ff.prog[`NVM_PRG_LAT] |=> !r_ff.prog[`NVM_PRG_LAT])
		else $error("latch control set with zero divider");

	a_div_zero_idle: assert property (@(posedge i_mclk) disable iff (i_reset)
		div_zero && r_ff.state == nvm_ctl_pkg::NVM_IDLE |=> !r_ff.hv)
		else $error("zero divider started a cycle");

	a_prot_pgm: assert property (@(posedge i_mclk) disable iff (i_reset)
		$past(r_ff.prog[`NVM_PRG_PGM]) |-> $stable(r_ff.prot))
		else $error("protect changed while programming");

	a_bulk_protect_lock: assert property (@(posedge i_mclk) disable iff (i_reset)
		$past(r_ff.plck) |-> $stable(r_ff.prog[`NVM_PRG_BULK_PROT]))
		else $error("bulk protect changed while locked");

	a_rdata_idle: assert property (@(posedge i_mclk) disable iff (i_reset)
		!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
		else $error("read data outside its cycle");

	a_word_aligned: assert property (@(posedge i_mclk) disable iff (i_reset)
		r_ff.lat_word |-> !r_ff.lat_addr[0])
		else $error("misaligned word latched");

	a_cfg_special: assert property (@(posedge i_mclk) disable iff (i_reset)
		!$past(special) && !$past(r_ff.boot) |-> $stable(r_ff.mcr_hi))
		else $error("config bits written in normal mode");

	a_plck_once: assert property (@(posedge i_mclk) disable iff (i_reset)
		$past(r_ff.plck_wr_done) && !$past(special) |-> $stable(r_ff.plck))
		else $error("protect lock rewritten in normal mode");

	a_tst_special: assert property (@(posedge i_mclk) disable iff (i_reset)
		!$past(special) |-> $stable(r_ff.tst))
		else $error("test bits written in normal mode");

	a_div_latch: assert property (@(posedge i_mclk) disable iff (i_reset)
		$past(r_ff.prog[`NVM_PRG_LAT]) && !$past(r_ff.boot) |-> $stable(r_ff.div))
		else $error("divider written with latch set");

	a_ticks_idle: assert property (@(posedge i_mclk) disable iff (i_reset)
		r_ff.state == nvm_ctl_pkg::NVM_IDLE |=> r_ff.ticks == 16'h0000)
		else $error("tick count not cleared when idle");

	a_ticks_count: assert property (@(posedge i_mclk) disable iff (i_reset)
		r_ff.hv && tick && r_ff.ticks < 16'(`NVM_PULSE_TICKS)
		|=> r_ff.ticks == $past(r_ff.ticks) + 16'h0001)
		else $error("tick not counted");

	a_clk_run: assert property (@(posedge i_mclk) disable iff (i_reset)
		!r_ff.wai |-> o_module_clk_en)
		else $error("module clock gated with wait-stop clear");

	a_bulk_blocked: assert property (@(posedge i_mclk) disable iff (i_reset)
		bulk_req && r_ff.prog[`NVM_PRG_BULK_PROT] |-> prot_hit)
		else $error("bulk erase not blocked");

	a_shadow_prot: assert property (@(posedge i_mclk) disable iff (i_reset)
		shadow_hit && r_ff.prot[`NVM_PROT_SHP] |-> prot_hit)
		else $error("shadow word not protected");
endmodule : nvm_ctl
`default_nettype wire

// ===== rtl/nvm_ctl_pkg.sv
package nvm_ctl_pkg;
	typedef enum logic [1:0] {
		NVM_IDLE = 2'b01,
		NVM_BUSY = 2'b10
	} nvm_state_e;
	typedef struct packed {
		nvm_state_e  state;
		logic [9:0]  div;
		logic        div_wr_done;
		logic [3:0]  mcr_hi;
		logic        wai;
		logic        plck;
		logic        plck_wr_done;
		logic        dummy_bit;
		logic [7:0]  prot;
		logic [7:0]  tst;
		logic [7:0]  prog;
		logic [11:0] lat_addr;
		logic [15:0] lat_data;
		logic        lat_word;
		logic        lat_valid;
		logic [9:0]  presc;
		logic [15:0] ticks;
		logic        hv;
		logic [7:0]  rdata;
		logic        boot;
	} nvm_state_s;
endpackage : nvm_ctl_pkg

// ===== rtl/nvm_ctl_regs.svh
`ifndef NVM_CTL_REGS_SVH
`define NVM_CTL_REGS_SVH
// register offsets
`define NVM_OFF_DIV_HI      8'hEE
`define NVM_OFF_DIV_LO      8'hEF
`define NVM_OFF_MCR         8'hF0
`define NVM_OFF_PROT        8'hF1
`define NVM_OFF_TST         8'hF2
`define NVM_OFF_PROG        8'hF3
// program control fields
`define NVM_PRG_BULK_PROT   7
`define NVM_PRG_AUTO        5
`define NVM_PRG_BYTE        4
`define NVM_PRG_ROW         3
`define NVM_PRG_ERASE       2
`define NVM_PRG_LAT         1
`define NVM_PRG_PGM         0
// module config fields
`define NVM_MCR_NOBDL       7
`define NVM_MCR_SHADOW_DIS  6
`define NVM_MCR_WAI         2
`define NVM_MCR_PLCK        1
`define NVM_MCR_DUMMY       0
`define NVM_PROG_RESET      8'h80
// protect register
`define NVM_PROT_SHP        6
`define NVM_PROT_RESET      8'h7F
// array map
`define NVM_SHADOW_HI       12'hFC0
`define NVM_SHADOW_LO       12'hFC1
`define NVM_ARRAY_BASE      12'h800
// timing, counted in self-time ticks
`define NVM_PULSE_US        10000
`define NVM_TICK_US         35
`define NVM_PULSE_TICKS     (`NVM_PULSE_US / `NVM_TICK_US)
`endif

// ===== verification/nvm_ctl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "nvm_ctl_regs.svh"
module nvm_ctl_tb_top;
	localparam int DIV = 5;
	localparam int DIV_NOM = 700;
	localparam int PULSE = `NVM_PULSE_TICKS * DIV;
	logic        mclk, rst, smode_n, waitm, rd, wr, awr, aword, rd_d;
	logic        lat, hv, ers, ssel, dbg, clken, opw;
	logic [1:0]  esz;
	logic [7:0]  ra, rwd, rdat, tick;
	logic [11:0] aad, opa;
	logic [15:0] shw, awd, opd;
	logic [31:0] seed;
	logic [7:0]  exq[$];
	int          miscompares, n_tests, i, k;

	nvm_ctl nvm_ctl_inst (.i_mclk(mclk), .i_reset(rst), .i_special_mode_n(smode_n),
		.i_wait_mode(waitm), .i_shadow_word(shw), .i_reg_addr(ra), .i_reg_wdata(rwd),
		.i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat), .i_arr_wr(awr),
		.i_arr_addr(aad), .i_arr_wdata(awd), .i_arr_word(aword),
		.o_latch_active(lat), .o_hv_enable(hv), .o_erase(ers), .o_erase_size(esz),
		.o_op_addr(opa), .o_op_data(opd), .o_op_word(opw), .o_shadow_select(ssel),
		.o_debug_lockout_disable(dbg), .o_module_clk_en(clken), .o_tick_count(tick));

	always #25 mclk = ~mclk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic results;
		$display("comparisons %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		wr <= 1'b1;
		ra <= a;
		rwd <= d;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk);
		exq.push_back(e);
		rd <= 1'b1;
		ra <= a;
		@(posedge mclk);
		rd <= 1'b0;
	endtask : rd_reg

	task automatic arr_wr(input logic [11:0] a, input logic [15:0] d, input logic w);
		@(posedge mclk);
		awr <= 1'b1;
		aad <= a;
		awd <= d;
		aword <= w;
		@(posedge mclk);
		awr <= 1'b0;
	endtask : arr_wr

	task automatic wait_hv(input logic v, input int lim);
		i = 0;
		while (hv !== v && i < lim) begin
			@(posedge mclk);
			i++;
		end
		chk("hv enable", {15'h0000, v}, {15'h0000, hv});
	endtask : wait_hv

	// read data stands only in the cycle after the strobe
	always @(posedge mclk) begin
		if (rd_d)
			chk("read data", {8'h00, exq.pop_front()}, {8'h00, rdat});
		rd_d <= rd;
	end

	initial begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		results();
	end

	initial begin
		{mclk, smode_n, waitm, rd, wr, awr, aword} = 7'h20;
		{rst, ra, rwd, aad, awd, miscompares, n_tests} = '0;
		rst = 1'b1;
		seed = lfsr(32'hC54CB82D);
		shw = {seed[31], 1'b0, seed[29:26], 10'h003};
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
		rd_reg(`NVM_OFF_DIV_HI, 8'h00);
		rd_reg(`NVM_OFF_DIV_LO, 8'h03);
		rd_reg(`NVM_OFF_MCR, {shw[15:12], 4'hC});
		rd_reg(`NVM_OFF_PROG, 8'h80);
		rd_reg(`NVM_OFF_PROT, `NVM_PROT_RESET);
		wr_reg(`NVM_OFF_TST, 8'hFF);
		rd_reg(`NVM_OFF_TST, 8'h00);
		rd_reg(8'h10, 8'h00);
		wr_reg(`NVM_OFF_DIV_LO, DIV[7:0]);
		wr_reg(`NVM_OFF_DIV_LO, 8'h09);
		rd_reg(`NVM_OFF_DIV_LO, DIV[7:0]);
		wr_reg(`NVM_OFF_PROT, 8'h00);
		rd_reg(`NVM_OFF_PROT, 8'h00);
		wr_reg(`NVM_OFF_PROG, 8'h23);
		rd_reg(`NVM_OFF_PROG, 8'h22);
		seed = lfsr(seed);
		arr_wr(12'h900, seed[15:0], 1'b0);
		wr_reg(`NVM_OFF_PROG, 8'h23);
		wait_hv(1'b1, 10);
		arr_wr(12'hA00, ~seed[15:0], 1'b1);
		wr_reg(`NVM_OFF_PROT, 8'h20);
		rd_reg(`NVM_OFF_PROG, 8'h23);
		rd_reg(`NVM_OFF_PROT, 8'h00);
		@(negedge mclk);
		chk("latched address", 16'h0900, {4'h0, opa});
		chk("latched data", seed[15:0], opd);
		chk("latched size", 16'h0000, {15'h0000, opw});
		chk("latch active", 16'h0001, {15'h0000, lat});
		wait_hv(1'b0, PULSE + 50);
		chk("pulse length", 16'h0001, {15'h0000, i >= PULSE - 40});
		rd_reg(`NVM_OFF_PROG, 8'h22);
		wr_reg(`NVM_OFF_PROT, 8'h20);
		arr_wr(12'h850, seed[31:16], 1'b0);
		wr_reg(`NVM_OFF_PROG, 8'h23);
		repeat (30) @(posedge mclk);
		chk("blocked start", 16'h0000, {15'h0000, hv});
		chk("tick count", 16'h0000, {8'h00, tick});
		rd_reg(`NVM_OFF_PROG, 8'h23);
		wr_reg(`NVM_OFF_PROG, 8'h22);
		for (k = 0; k < 4; k++) begin
			wr_reg(`NVM_OFF_PROG, {3'b000, k[1], k[0], 3'b100});
			@(negedge mclk);
			chk("erase size", {14'h0000, k[1] ? 2'b10 : {1'b0, k[0]}}, {14'h0000, esz});
			chk("erase select", 16'h0001, {15'h0000, ers});
		end
		wr_reg(`NVM_OFF_PROG, 8'h02);
		arr_wr(12'hFC1, seed[15:0], 1'b0);
		@(negedge mclk);
		chk("shadow select", 16'h0001, {15'h0000, ssel});
		wr_reg(`NVM_OFF_PROG, 8'h00);
		wr_reg(`NVM_OFF_MCR, {~shw[15], 1'b1, shw[13:12], 4'h2});
		wr_reg(`NVM_OFF_PROT, 8'h3F);
		rd_reg(`NVM_OFF_PROT, 8'h20);
		wr_reg(`NVM_OFF_MCR, {shw[15:12], 4'h4});
		rd_reg(`NVM_OFF_MCR, {shw[15:12], 4'hE});
		waitm <= 1'b1;
		@(negedge mclk);
		chk("module clock", 16'h0000, {15'h0000, clken});
		chk("debug lockout", {15'h0000, shw[15]}, {15'h0000, dbg});
		@(posedge mclk);
		smode_n <= 1'b0;
		wr_reg(`NVM_OFF_MCR, {~shw[15], 1'b1, shw[13:12], 4'h0});
		rd_reg(`NVM_OFF_MCR, {~shw[15], 1'b1, shw[13:12], 4'h8});
		wr_reg(`NVM_OFF_TST, 8'hA5);
		rd_reg(`NVM_OFF_TST, 8'hA5);
		wr_reg(`NVM_OFF_DIV_HI, DIV_NOM[15:8]);
		wr_reg(`NVM_OFF_DIV_LO, DIV_NOM[7:0]);
		rd_reg(`NVM_OFF_DIV_HI, {6'h00, DIV_NOM[9:8]});
		rd_reg(`NVM_OFF_DIV_LO, DIV_NOM[7:0]);
		@(negedge mclk);
		chk("debug lockout", {15'h0000, ~shw[15]}, {15'h0000, dbg});
		chk("module clock", 16'h0001, {15'h0000, clken});
		chk("shadow select", 16'h0000, {15'h0000, ssel});
		repeat (3) @(posedge mclk);
		results();
	end
endmodule : nvm_ctl_tb_top
`default_nettype wire
